// *** design/sbce_pkg.sv ***
// Purpose: Constants and types for the system bus command encoder
// Assumes: One system clock at 40 MHz; all latencies counted in processor_cycles
// Notes: Command/identifier encoding, alignment, release latency, protocol error
//
// How it works
// [R1] Request seen one cycle before a request's last cycle: release within 4..6 cycles.
// [R2] Request seen idle or in the last cycle: release within 4..24 cycles.
// [R3] Agent drives reserved bits to one; our reserved bits are don't-care.
// [R4] Bit 4 of the five-bit code: zero command/address, one data identifier.
// [R5] Command bit 3: zero read, one write.
// [R6] Read command bit 2: zero single, one block read.
// [R7] Block read size: 0 two, 1 four, 2 eight words, 3 reserved.
// [R8] Eight-word reads only at 32-byte aligned address; else split into four-word reads. The core sends only one four-word read.
// [R9] Single read low bits give valid bytes minus one.
// [R10] Doubleword moves as two words; little endian low half first, big high first.
// [R11] Agent returns block read data in subblock order from addressed doubleword.
// [R12] Write command bit 2: zero single, one block write.
// [R13] Block write size: 0 two, 1 four words; 2 and 3 reserved.
// [R14] Single write low bits give valid bytes minus one.
// [R15] Block write sends first doubleword address, data sequential; eight words as two fours.
// [R16] Agent writes to the device only one word, one clock each.
// [R17] Identifier bit 3 zero marks last element, one any earlier element.
// [R18] Device data identifiers: error bit zero, check-enable bit one.
// [R19] Agent data bit 2: zero response data, one not response data.
// [R20] Agent data with bit 1 set raises a bus error.
// [R21] Device ignores bit 0 of agent identifiers.
// [R22] Addresses are 32-bit, aligned to transfer size.
// [R23] Accept data only with valid strobe asserted and a data identifier present.
// [R24] Missing last element hangs; bus request output toggles each clock until reset.
package sbce_pkg;
  localparam int unsigned CMD_W = 5;
  localparam int unsigned AD_W = 32;
  localparam logic [4:0] CMD_BIT_DATA = 5'h10;
  localparam int unsigned B_KIND = 4;
  localparam int unsigned B_WRITE = 3;
  localparam int unsigned B_BLOCK = 2;
  localparam int unsigned B_LAST = 3;
  localparam int unsigned B_RESP = 2;
  localparam int unsigned B_ERR = 1;
  localparam int unsigned B_CHK = 0;
  localparam logic [1:0] BSZ_2W = 2'h0;
  localparam logic [1:0] BSZ_4W = 2'h1;
  localparam logic [1:0] BSZ_8W = 2'h2;
  localparam logic [4:0] ALIGN8_MASK = 5'h1F;
  localparam logic [2:0] ID_TAIL = 3'h1;
  localparam logic [2:0] RSV_ONE = 3'h7;
  localparam logic [3:0] CNT_4W = 4'h4;
  localparam logic [3:0] CNT_2W = 4'h2;
  localparam logic [3:0] CNT_1W = 4'h1;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned REL_MIN_CYC = 4;
  localparam int unsigned REL_CAT1_MAX_CYC = 6;
  localparam int unsigned REL_CAT2_MAX_CYC = 24;
  localparam logic [4:0] REL_DELAY = 5'h4;
  localparam logic [4:0] CAT1_MAX = 5'h6;
  localparam logic [4:0] CAT2_MAX = 5'h18;
  localparam logic [15:0] HANG_LIMIT = 16'h0400;

  typedef enum logic [4:0] {
    SBCE_IDLE = 5'h01,
    SBCE_ADDR = 5'h02,
    SBCE_DATA = 5'h04,
    SBCE_WAIT = 5'h08,
    SBCE_SLAVE = 5'h10
  } sbce_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic block;
    logic [1:0] size;
    logic [31:0] addr;
    logic [63:0] wdata;
  } sbce_req_t;

  typedef struct packed {
    logic done;
    logic [31:0] data;
    logic last;
    logic resp;
    logic bus_err;
  } sbce_rsp_t;
endpackage : sbce_pkg

// *** design/sbce_core.sv ***
// Purpose: Processor-side bus engine: encodes commands, moves data, releases the bus
// Assumes: Pins are synchronous to clk_i; one core request at a time
// Notes: Two-way bus pins are split into input, output and output enable
//
// The plain strobed port is this design's own decision.
`default_nettype none
module sbce_core #(
  parameter logic [15:0] HANG_CYCLES = sbce_pkg::HANG_LIMIT
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic big_endian_i,
  input wire sbce_pkg::sbce_req_t req_i,
  output logic req_ready_o,
  output sbce_pkg::sbce_rsp_t rsp_o,
  input wire logic ext_bus_request_n_i,
  input wire logic ext_valid_strobe_n_i,
  input wire logic [4:0] command_bus_i,
  input wire logic [31:0] addr_data_bus_i,
  output logic [4:0] command_bus_o,
  output logic [31:0] addr_data_bus_o,
  output logic bus_oe_o,
  output logic proc_bus_master_n_o,
  output logic proc_bus_request_n_o,
  output logic bus_error_o
);
  import sbce_pkg::*;

  typedef struct packed {
    sbce_state_t st;
    logic write;
    logic block;
    logic [1:0] size;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic [3:0] left;
    logic [3:0] sent;
    logic second;
    logic split;
    logic [4:0] rel_cnt;
    logic rel_pend;
    logic [15:0] hang;
    logic hung;
    logic ready;
    sbce_rsp_t rsp;
    logic [4:0] cmd;
    logic [31:0] ad;
    logic oe;
    logic master_n;
    logic proc_bus_request_n_n;
    logic berr;
  } sbce_core_t;

  sbce_core_t s;
  sbce_core_t next_s;
  logic data_in;
  logic last_cycle;

  ////////////////////////////////////////////////////////////////////////////
  // Incoming data qualified by strobe and identifier type
  assign data_in = !ext_valid_strobe_n_i && command_bus_i[B_KIND]; // see [R23] [R4]
  assign last_cycle = (s.st == SBCE_DATA) && s.write && (s.left == CNT_1W);

  always_comb begin
    next_s = s;
    next_s.rsp.done = 1'b0;
    next_s.berr = 1'b0;
    if (s.hung) begin
      next_s.proc_bus_request_n_n = !s.proc_bus_request_n_n; // see [R24]
      next_s.oe = 1'b0;
    end else begin
      // Release latency: start counting when the agent asks for the bus
      if (!ext_bus_request_n_i && !s.rel_pend && s.master_n == 1'b0) begin
        next_s.rel_pend = 1'b1;
        next_s.rel_cnt = 5'h0;
      end else if (s.rel_pend) begin
        next_s.rel_cnt = s.rel_cnt + 5'h1;
      end
      case (s.st)
        SBCE_IDLE: begin
          next_s.oe = 1'b0;
          next_s.ready = 1'b1;
          if (s.rel_pend && s.rel_cnt + 5'h1 >= REL_DELAY) begin // see [R1] [R2]
            next_s.st = SBCE_SLAVE;
            next_s.master_n = 1'b1;
            next_s.rel_pend = 1'b0;
            next_s.ready = 1'b0;
          end else if (req_i.valid && s.ready && ext_bus_request_n_i) begin
            next_s.ready = 1'b0;
            next_s.write = req_i.write;
            next_s.block = req_i.block;
            next_s.wdata = req_i.wdata;
            next_s.second = 1'b0;
            // Kept here, since the requester may change its fields once taken
            next_s.split = req_i.write && req_i.block && req_i.size == BSZ_8W; // see [R15]
            next_s.size = req_i.size;
            // Unaligned eight-word reads fall back to one four-word read
            if (!req_i.write && req_i.block && req_i.size == BSZ_8W
                && (req_i.addr[4:0] & ALIGN8_MASK) != 5'h00) begin
              next_s.size = BSZ_4W; // see [R8]
            end
            // Eight-word writes go as two four-word blocks
            if (req_i.write && req_i.block && req_i.size == BSZ_8W) begin
              next_s.size = BSZ_4W; // see [R15] [R13]
            end
            // Align address to transfer size
            if (req_i.block) begin
              next_s.addr = {req_i.addr[31:3], 3'h0}; // see [R22]
            end else if (req_i.size == 2'h3) begin
              next_s.addr = {req_i.addr[31:2], 2'h0}; // see [R22]
            end else if (req_i.size == 2'h1) begin
              next_s.addr = {req_i.addr[31:1], 1'h0};
            end else begin
              next_s.addr = req_i.addr;
            end
            if (req_i.write && req_i.block) begin
              next_s.addr = {req_i.addr[31:5], req_i.size == BSZ_8W ? 2'h0 : req_i.addr[4:3], 3'h0}; // see [R15]
            end
            next_s.st = SBCE_ADDR;
          end
        end
        SBCE_ADDR: begin
          next_s.oe = 1'b1;
          next_s.ad = s.addr;
          next_s.cmd = {1'b0, s.write, s.block, s.size}; // see [R4] [R5] [R6] [R7] [R9] [R12] [R14]
          next_s.sent = 4'h0;
          if (!s.block) begin
            next_s.left = CNT_1W;
          end else if (s.size == BSZ_2W) begin
            next_s.left = CNT_2W;
          end else if (s.size == BSZ_4W) begin
            next_s.left = CNT_4W;
          end else begin
            next_s.left = CNT_4W + CNT_4W;
          end
          next_s.st = s.write ? SBCE_DATA : SBCE_WAIT;
          next_s.hang = 16'h0;
        end
        SBCE_DATA: begin
          // Low or high half first depending on endianness
          // A single transfer always carries the low word, whatever the byte order
          next_s.ad = (s.block && (s.sent[0] ^ big_endian_i)) ? s.wdata[63:32] : s.wdata[31:0]; // see [R10]
          next_s.cmd = {1'b1, s.left != CNT_1W, RSV_ONE[0], 1'b0, 1'b1}; // see [R17] [R18] [R3]
          next_s.sent = s.sent + 4'h1;
          next_s.left = s.left - 4'h1;
          if (s.left == CNT_1W) begin
            if (s.split && s.second == 1'b0) begin
              next_s.second = 1'b1;
              next_s.addr = s.addr + 32'h10; // see [R15]
              next_s.st = SBCE_ADDR;
            end else begin
              next_s.rsp.done = 1'b1;
              next_s.st = SBCE_IDLE;
            end
          end
        end
        SBCE_WAIT: begin
          next_s.oe = 1'b0;
          next_s.hang = s.hang + 16'h1;
          if (data_in) begin
            next_s.hang = 16'h0;
            next_s.rsp.done = 1'b1;
            next_s.rsp.data = addr_data_bus_i;
            next_s.rsp.last = !command_bus_i[B_LAST]; // see [R17]
            next_s.rsp.resp = !command_bus_i[B_RESP]; // see [R19]
            next_s.rsp.bus_err = command_bus_i[B_ERR]; // see [R20] [R21]
            next_s.berr = command_bus_i[B_ERR]; // see [R20]
            if (!command_bus_i[B_LAST]) begin
              next_s.st = SBCE_IDLE;
            end
          end else if (s.hang >= HANG_CYCLES) begin
            next_s.hung = 1'b1; // see [R24]
          end
        end
        SBCE_SLAVE: begin
          next_s.oe = 1'b0;
          next_s.master_n = 1'b1;
          // Agent single-word writes are accepted while slave
          if (data_in) begin
            next_s.rsp.done = 1'b1;
            next_s.rsp.data = addr_data_bus_i; // see [R16]
            next_s.rsp.last = 1'b1;
            next_s.rsp.resp = !command_bus_i[B_RESP];
            next_s.rsp.bus_err = command_bus_i[B_ERR];
            next_s.berr = command_bus_i[B_ERR];
          end
          if (ext_bus_request_n_i) begin
            next_s.master_n = 1'b0;
            next_s.st = SBCE_IDLE;
          end
        end
        default: begin
          next_s.st = SBCE_IDLE;
        end
      endcase
      if (s.rel_pend && s.rel_cnt + 5'h1 >= CAT2_MAX) begin
        next_s.st = SBCE_SLAVE; // see [R2]
        next_s.master_n = 1'b1;
        next_s.oe = 1'b0;
        next_s.rel_pend = 1'b0;
      end
      if (next_s.st == SBCE_IDLE && s.st != SBCE_IDLE && s.rel_pend && last_cycle) begin
        next_s.rel_pend = 1'b1; // see [R1]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
      s.st <= SBCE_IDLE;
      s.proc_bus_request_n_n <= 1'b1;
      s.cmd <= 5'h1F;
    end else begin
      s <= next_s;
    end
  end

  assign req_ready_o = s.ready;
  assign rsp_o = s.rsp;
  assign command_bus_o = s.cmd;
  assign addr_data_bus_o = s.ad;
  assign bus_oe_o = s.oe;
  assign proc_bus_master_n_o = s.master_n;
  assign proc_bus_request_n_o = s.proc_bus_request_n_n;
  assign bus_error_o = s.berr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_release_bound: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(ext_bus_request_n_i) && !s.master_n && !s.hung |-> ##[1:24] proc_bus_master_n_o) // see [R2]
    else $error("bus not released in time");
  a_release_min: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(ext_bus_request_n_i) && !s.master_n && !s.hung |-> ##1 !proc_bus_master_n_o [*4]) // see [R1]
    else $error("bus released too early");
  a_cmd_kind: assert property (@(posedge clk_i) disable iff (srst_i)
    s.st == SBCE_ADDR |=> !command_bus_o[B_KIND]) // see [R4]
    else $error("address cycle without command code");
  a_data_ident: assert property (@(posedge clk_i) disable iff (srst_i)
    s.st == SBCE_DATA |=> command_bus_o[B_KIND] && !command_bus_o[B_ERR] && command_bus_o[B_CHK]) // see [R18]
    else $error("bad outgoing data identifier");
  a_block_align: assert property (@(posedge clk_i) disable iff (srst_i)
    s.st == SBCE_ADDR && s.block |=> addr_data_bus_o[2:0] == 3'h0) // see [R22]
    else $error("block address not aligned");
  a_eight_align: assert property (@(posedge clk_i) disable iff (srst_i)
    s.st == SBCE_ADDR && s.block && s.size == BSZ_8W |-> s.addr[4:0] == 5'h00) // see [R8]
    else $error("eight-word read unaligned");
  a_last_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    s.st == SBCE_DATA && s.left == CNT_1W |=> !command_bus_o[B_LAST]) // see [R17]
    else $error("last element not flagged");
  a_bus_error: assert property (@(posedge clk_i) disable iff (srst_i)
    s.st == SBCE_WAIT && !s.hung && data_in && command_bus_i[B_ERR] |=> bus_error_o) // see [R20]
    else $error("bus error not raised");
  a_hang_toggle: assert property (@(posedge clk_i) disable iff (srst_i)
    s.hung |=> proc_bus_request_n_o != $past(proc_bus_request_n_o)) // see [R24]
    else $error("hang toggle missing");
  c_write_done: cover property (@(posedge clk_i) s.st == SBCE_DATA ##1 s.st == SBCE_IDLE);
  c_read_done: cover property (@(posedge clk_i) s.st == SBCE_WAIT && data_in);
  c_release: cover property (@(posedge clk_i) s.st == SBCE_SLAVE);
  c_hang: cover property (@(posedge clk_i) s.hung);
endmodule : sbce_core
`default_nettype wire

// *** verif/sbce_agent.sv ***
// Purpose: External agent model that answers processor reads
// Assumes: Words come back in index order, one word per clock
// Notes: slow_i adds bogus cycles first; err_i flags the last word
`default_nettype none
module sbce_agent (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [4:0] cmd_i,
  input wire logic [31:0] ad_i,
  input wire logic oe_i,
  input wire logic slow_i,
  input wire logic err_i,
  input wire logic mute_i,
  output logic valid_n_o,
  output logic [4:0] cmd_o,
  output logic [31:0] ad_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int left;
  int idx;
  int gap;
  logic [31:0] base;
  initial begin
    valid_n_o = 1'b1;
    cmd_o = 5'h0F;
    ad_o = 32'h0;
  end
  always @(posedge clk_i) begin
    valid_n_o <= 1'b1;
    cmd_o <= 5'h0F;
    // Idle bus shows the inverse of its last value, so a stale copy never matches
    ad_o <= ~ad_o;
    if (srst_i) begin
      left <= 0;
    end else if (oe_i && cmd_i[4:3] == 2'h0) begin
      left <= cmd_i[2] ? 2 << cmd_i[1:0] : 1;
      base <= ad_i;
      idx <= 0;
      gap <= slow_i ? 3 : 1;
    end else if (left > 0 && !mute_i) begin
      if (gap > 0) begin
        // Slow answers show a data code without strobe, then a strobe beside a command code
        gap <= gap - 1;
        valid_n_o <= !(slow_i && gap == 1);
        if (gap == 2) cmd_o <= 5'h1F;
      end else begin
        valid_n_o <= 1'b0;
        cmd_o <= {1'b1, left > 1, 1'b0, err_i && left == 1, 1'b1};
        ad_o <= base ^ 32'h5A5AC3C3 ^ idx;
        idx <= idx + 1;
        left <= left - 1;
      end
    end
  end
endmodule : sbce_agent
`default_nettype wire

// *** verif/sbce_bench.sv ***
// Purpose: Self-checking bench for the system bus command encoder
// Assumes: Hang count shortened to 16 cycles
// Notes: Stimulus from an LFSR with a fixed start value
`default_nettype none
module sbce_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import sbce_pkg::*;
  logic clk_i, srst_i, big_endian_i, ext_bus_request_n_i, slow, err, mute, p;
  logic req_ready_o, bus_oe_o, proc_bus_master_n_o, proc_bus_request_n_o, bus_error_o, ext_valid_strobe_n_i;
  logic [4:0] command_bus_i, command_bus_o;
  logic [31:0] addr_data_bus_i, addr_data_bus_o, lf, a;
  logic [63:0] d;
  logic [1:0] s;
  logic [2:0] rl;
  sbce_req_t req_i;
  sbce_rsp_t rsp_o;
  logic [36:0] cq[$], dq[$];
  logic [31:0] rspq[$];
  int errors, comparisons, berr, n;
  localparam logic [36:0] ID_MASK = {5'h1B, 32'hFFFFFFFF};
  ////////////////////////////////////////////////////////////
  sbce_core #(.HANG_CYCLES(16'h0010)) sbce_core_i (.clk_i(clk_i), .srst_i(srst_i),
    .big_endian_i(big_endian_i), .req_i(req_i), .req_ready_o(req_ready_o), .rsp_o(rsp_o),
    .ext_bus_request_n_i(ext_bus_request_n_i), .ext_valid_strobe_n_i(ext_valid_strobe_n_i),
    .command_bus_i(command_bus_i), .addr_data_bus_i(addr_data_bus_i), .command_bus_o(command_bus_o),
    .addr_data_bus_o(addr_data_bus_o), .bus_oe_o(bus_oe_o), .proc_bus_master_n_o(proc_bus_master_n_o),
    .proc_bus_request_n_o(proc_bus_request_n_o), .bus_error_o(bus_error_o));
  sbce_agent sbce_agent_i (.clk_i(clk_i), .srst_i(srst_i), .cmd_i(command_bus_o), .ad_i(addr_data_bus_o),
    .oe_i(bus_oe_o), .slow_i(slow), .err_i(err), .mute_i(mute), .valid_n_o(ext_valid_strobe_n_i),
    .cmd_o(command_bus_i), .ad_o(addr_data_bus_i));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step
  function automatic logic [31:0] half(input logic [63:0] v, input logic hi);
    return hi ? v[63:32] : v[31:0];
  endfunction : half
  function automatic logic [31:0] rword(input logic [31:0] v, input int i);
    return v ^ 32'h5A5AC3C3 ^ i;
  endfunction : rword
  task automatic chk(input logic [36:0] got, input logic [36:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // Starts just after a rising edge; waits for the take, then for nr responses
  task automatic run(input logic w, b, input logic [1:0] sz, input logic [31:0] ad, input int nr);
    cq = {};
    dq = {};
    rspq = {};
    berr = 0;
    n = 0;
    req_i <= '{1'b1, w, b, sz, ad, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 99);
    req_i.valid <= 1'b0;
    n = 0;
    while (rspq.size() < nr && n < 99) begin
      @(posedge clk_i);
      n++;
    end
    repeat (8) @(posedge clk_i);
  endtask : run
  ////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (bus_oe_o === 1'b1 && command_bus_o[4] === 1'b0) cq.push_back({command_bus_o, addr_data_bus_o});
    if (bus_oe_o === 1'b1 && command_bus_o[4] === 1'b1) dq.push_back({command_bus_o, addr_data_bus_o});
    if (rsp_o.done === 1'b1) rspq.push_back(rsp_o.data);
    if (rsp_o.done === 1'b1) rl <= {rsp_o.last, rsp_o.resp, rsp_o.bus_err};
    if (bus_error_o === 1'b1) berr++;
  end
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    close_out();
  end
  initial begin
    {srst_i, ext_bus_request_n_i, big_endian_i, slow, err, mute} = 6'h30;
    req_i = '0;
    d = 64'h0;
    lf = 32'hAF2284D1;
    errors = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      lf = step(lf);
      a = lf;
      lf = step(lf);
      d = {lf, ~a};
      s = lf[1:0];
      slow <= lf[4];
      big_endian_i <= lf[7];
      if (s[0]) a[0] = 1'b0;
      if (s == 2'h3) a[1] = 1'b0;
      run(1'b1, 1'b0, s, a, 1);
      chk(cq[0], {3'b010, s, a}, "single write command");
      chk(dq[0] & ID_MASK, {5'h11, d[31:0]}, "single write data");
      run(1'b0, 1'b0, s, a, 1);
      chk(cq[0], {3'b000, s, a}, "single read command");
      chk(rspq[0], rword(a, 0), "single read data");
      chk(rl, 3'h6, "single read flags");
      a[2:0] = 3'h0;
      run(1'b1, 1'b1, BSZ_2W, a, 1);
      chk(cq[0], {3'b011, BSZ_2W, a}, "block write command");
      chk(dq[0] & ID_MASK, {5'h19, half(d, big_endian_i)}, "first word");
      chk(dq[1] & ID_MASK, {5'h11, half(d, !big_endian_i)}, "second word");
      run(1'b0, 1'b1, BSZ_2W, a, 2);
      chk(cq[0], {3'b001, BSZ_2W, a}, "block read command");
      chk(rspq[1], rword(a, 1), "block read data");
      chk(rl, 3'h6, "block read flags");
    end
    slow <= 1'b1;
    a = {lf[31:5], 5'h00};
    run(1'b0, 1'b1, BSZ_8W, a, 8);
    chk(cq[0], {3'b001, BSZ_8W, a}, "eight word read");
    for (int i = 0; i < 8; i++) chk(rspq[i], rword(a, i), "eight word data");
    a[4:3] = 2'h1;
    run(1'b0, 1'b1, BSZ_8W, a, 4);
    chk(cq[0], {3'b001, BSZ_4W, a}, "split read");
    chk(rspq.size(), 4, "split read length");
    a[4:3] = 2'h0;
    run(1'b1, 1'b1, BSZ_8W, a, 1);
    chk(cq[0], {3'b011, BSZ_4W, a}, "first half block");
    chk(cq[1], {3'b011, BSZ_4W, a + 32'h10}, "second half block");
    for (int i = 0; i < 8; i++) chk(dq[i][35], i % 4 != 3, "last flags");
    err <= 1'b1;
    run(1'b0, 1'b0, 2'h3, a, 1);
    chk(berr, 1, "bus error pulses");
    chk(rl, 3'h7, "error read flags");
    err <= 1'b0;
    ext_bus_request_n_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (proc_bus_master_n_o !== 1'b1 && n < 40);
    chk(n > 4 && n <= 25, 1'b1, "release latency");
    ext_bus_request_n_i <= 1'b1;
    repeat (30) @(posedge clk_i);
    mute <= 1'b1;
    run(1'b0, 1'b0, 2'h3, a, 1);
    p = proc_bus_request_n_o;
    repeat (4) begin
      @(posedge clk_i);
      chk(proc_bus_request_n_o, !p, "hang toggle");
      p = proc_bus_request_n_o;
    end
    srst_i <= 1'b1;
    mute <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({bus_oe_o, proc_bus_master_n_o, proc_bus_request_n_o, command_bus_o}, 8'h3F, "reset state");
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    close_out();
  end
endmodule : sbce_bench
`default_nettype wire
